// ==== common/sem_pkg.sv ====
// Purpose: shared constants and types for the serial engine map and status block
// Assumes: 8-bit register port, 16-bit register address
// Notes:   bit positions below are listed separately for each of the two engine registers
package sem_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned EP_W   = 4;
    localparam int unsigned NFILT  = 4;

    localparam logic [ADDR_W-1:0] OFS_ENGINE_STATUS      = 16'h7f93;
    localparam logic [ADDR_W-1:0] OFS_ENGINE_CONTROL_ONE = 16'h7f94;

    localparam logic [DATA_W-1:0] RST_ENGINE_STATUS      = 8'h03;
    localparam logic [DATA_W-1:0] RST_ENGINE_CONTROL_ONE = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_IDLE             = 8'h00;

    // status bit positions
    localparam int unsigned ST_ERR     = 7;
    localparam int unsigned ST_TIMEOUT = 6;
    localparam int unsigned ST_SETUP   = 5;
    localparam int unsigned ST_SOF     = 4;
    localparam int unsigned ST_PRE     = 3;
    localparam int unsigned ST_ACK     = 2;
    localparam int unsigned ST_BUSRST  = 1;
    localparam int unsigned ST_TEND    = 0;

    // control bit positions
    localparam int unsigned CT_DMA_INHIBIT = 7;
    localparam int unsigned CT_RX_ACCEPT   = 6;
    localparam int unsigned CT_TX_LAST     = 5;
    localparam int unsigned CT_RX_OVERFLOW = 4;
    localparam int unsigned CT_STUFF_ERR   = 3;
    localparam int unsigned CT_TEND        = 2;
    localparam int unsigned CT_RX_TAG      = 1;
    localparam int unsigned CT_TX_OK       = 0;

    // writable control bits 7:2
    localparam logic [DATA_W-1:0] CT_WR_MASK = 8'hfc;

    // filter index: 0 primary address, 1..3 alternate filters
    localparam logic [1:0] FILT_PRIMARY = 2'h0;
    localparam logic [1:0] FILT_ALT1    = 2'h1;
    localparam logic [1:0] FILT_ALT2    = 2'h2;
    localparam logic [1:0] FILT_ALT3    = 2'h3;

    typedef enum logic [1:0] {
        SEM_PID_OUT   = 2'b00,
        SEM_PID_IN    = 2'b01,
        SEM_PID_SETUP = 2'b10,
        SEM_PID_SOF   = 2'b11
    } sem_pid_t;

    // token seen by the engine, with address-filter hits
    typedef struct packed {
        logic             valid;
        sem_pid_t         kind;
        logic [EP_W-1:0]  wire_ep;
        logic [NFILT-1:0] hit;
    } sem_token_t;

    // transaction outcome, all one-cycle pulses except bus_se0
    typedef struct packed {
        logic start;
        logic done;
        logic error;
        logic timeout;
        logic pre_seen;
        logic bus_se0;
        logic sys_reset;
    } sem_event_t;

endpackage : sem_pkg

// ==== core/sem_engine_map_status.sv ====
// Purpose: endpoint translation, engine status and engine control one register
// Assumes: all engine inputs synchronous to clk; token fields stable with valid
// Notes:   register port answers reads one cycle later, never stalls
//
// Contract
// - primary keeps wire endpoint; alternate n gives 4n plus wire endpoint mod 4.
// - alternate three folds wire endpoints 1, 5, 9, 13 to internal 13.
// - status bit 7 flags error of last transaction, read after end flag.
// - status bit 6 flags inter-packet timeout of last transaction, valid at end.
// - status bit 5 shows the received token was a setup token.
// - status bit 4 shows a start-of-frame token, valid while end flag low.
// - status bit 3 sets on valid sync followed by preamble identifier.
// - status bit 2 shows last transaction ended with no error or timeout.
// - status bit 1 set during long bus reset, cleared by system reset.
// - status bit 0 rises at transaction end, falls at transaction start.
// - status register read-only, mirrors engine state, resets to 0x03.
// - control bit 7 inhibits engine dma transfers for microcontroller takeover.
// - control bit 6 forces acknowledge during receive regardless of outcome.
// - control bit 5 marks next transmit fifo byte as final payload byte.
// - control bit 4 raises receive overflow and empties receive fifo.
// - control bit 3 corrupts transmission to cause host bit-stuff error.
// - control bit 2 forces a transaction end condition.
// - control bit 1 reads back live receive tag state.
// - control bit 0 reads back live transmit success state.
// - alternate filter counts only when its enable bit is set.
// - translation also selects the transmit queue for in tokens.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps

module sem_engine_map_status
    import sem_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                resetn,
    // register port
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    // token and filters
    input  sem_token_t               token,
    input  wire logic [NFILT-1:1]    alt_filter_enable,
    output logic                     ep_valid,
    output logic      [EP_W-1:0]     internal_ep,
    output logic                     endpoint_accept,
    output logic                     tx_queue_pop,
    // engine events and live state
    input  sem_event_t               evt,
    input  wire logic                rx_tag_state,
    input  wire logic                tx_success_state,
    // engine side of the overrides
    input  wire logic                dma_req,
    output logic                     dma_grant,
    input  wire logic                rx_ack_req,
    output logic                     rx_ack_send,
    input  wire logic                tx_fifo_wr,
    output logic                     tx_last_byte,
    output logic                     rx_overflow_event,
    output logic                     rx_fifo_flush,
    output logic                     inject_stuff_error,
    output logic                     inject_transaction_end,
    output logic                     engine_dma_inhibit,
    output logic                     force_rx_accept,
    output logic                     transaction_end
);

    // translate wire endpoint for a filter index
    function automatic logic [EP_W-1:0] map_ep(input logic [1:0] filt,
                                               input logic [EP_W-1:0] wep);
        logic [EP_W-1:0] r;
        r = wep;
        if (filt != FILT_PRIMARY) begin
            r = {filt, wep[1:0]};
        end
        return r;
    endfunction : map_ep

    // register address decode, used by read and write paths
    function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction : is_reg

    logic [DATA_W-1:0] status_r;
    logic [DATA_W-1:0] ctrl_r;
    logic [DATA_W-1:0] ctrl_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [EP_W-1:0]   ep_r;
    logic              ep_valid_r;
    logic              accept_r;
    logic              pop_r;
    logic              ovf_prev_r;
    logic [1:0]        filt_sel;
    logic              filt_hit;
    logic              forced_end;
    logic              end_event;
    logic              wr_ctrl;
    logic              wr_status_ignored;

    assign wr_ctrl           = reg_wr && is_reg(reg_addr, OFS_ENGINE_CONTROL_ONE);
    assign wr_status_ignored = reg_wr && is_reg(reg_addr, OFS_ENGINE_STATUS);

    // filter select: primary first, then enabled alternates in order
    always_comb begin
        filt_sel = FILT_PRIMARY;
        filt_hit = 1'b0;
        if (token.hit[FILT_PRIMARY]) begin
            filt_sel = FILT_PRIMARY;
            filt_hit = 1'b1;
        end else if (token.hit[FILT_ALT1] && alt_filter_enable[FILT_ALT1]) begin
            filt_sel = FILT_ALT1;
            filt_hit = 1'b1;
        end else if (token.hit[FILT_ALT2] && alt_filter_enable[FILT_ALT2]) begin
            filt_sel = FILT_ALT2;
            filt_hit = 1'b1;
        end else if (token.hit[FILT_ALT3] && alt_filter_enable[FILT_ALT3]) begin
            filt_sel = FILT_ALT3;
            filt_hit = 1'b1;
        end
    end

    // endpoint translation, captured once per token
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ep_r       <= '0;
            ep_valid_r <= 1'b0;
            accept_r   <= 1'b0;
            pop_r      <= 1'b0;
        end else begin
            ep_valid_r <= token.valid;
            accept_r   <= token.valid && filt_hit;
            // sof carries no endpoint, so it never pops a queue
            pop_r      <= token.valid && filt_hit && (token.kind == SEM_PID_IN);
            if (token.valid) begin
                ep_r <= map_ep(filt_sel, token.wire_ep);
            end
        end
    end

    assign ep_valid        = ep_valid_r;
    assign internal_ep     = ep_r;
    assign endpoint_accept = accept_r;
    assign tx_queue_pop    = pop_r;

    // control register, bits 1:0 are not stored
    always_comb begin
        ctrl_nxt = ctrl_r;
        // one-shot: the flagged byte consumes the last-byte request
        if (tx_fifo_wr) begin
            ctrl_nxt[CT_TX_LAST] = 1'b0;
        end
        // a fresh write wins over the consume in the same cycle
        if (wr_ctrl) begin
            ctrl_nxt = reg_wdata & CT_WR_MASK;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= RST_ENGINE_CONTROL_ONE;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovf_prev_r <= 1'b0;
        end else begin
            ovf_prev_r <= ctrl_r[CT_RX_OVERFLOW];
        end
    end

    assign engine_dma_inhibit     = ctrl_r[CT_DMA_INHIBIT];
    assign dma_grant              = dma_req && !ctrl_r[CT_DMA_INHIBIT];
    assign force_rx_accept        = ctrl_r[CT_RX_ACCEPT];
    assign rx_ack_send            = rx_ack_req || ctrl_r[CT_RX_ACCEPT];
    assign tx_last_byte           = tx_fifo_wr && ctrl_r[CT_TX_LAST];
    assign rx_overflow_event      = ctrl_r[CT_RX_OVERFLOW] && !ovf_prev_r;
    assign rx_fifo_flush          = ctrl_r[CT_RX_OVERFLOW];
    assign inject_stuff_error     = ctrl_r[CT_STUFF_ERR];
    assign inject_transaction_end = ctrl_r[CT_TEND];
    assign forced_end             = ctrl_r[CT_TEND];
    assign end_event              = evt.done || forced_end;

    // outcome bits, latched at the end of each transaction
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_r[ST_ERR]     <= RST_ENGINE_STATUS[ST_ERR];
            status_r[ST_TIMEOUT] <= RST_ENGINE_STATUS[ST_TIMEOUT];
            status_r[ST_ACK]     <= RST_ENGINE_STATUS[ST_ACK];
        end else if (end_event) begin
            status_r[ST_ERR]     <= evt.error;
            status_r[ST_TIMEOUT] <= evt.timeout;
            status_r[ST_ACK]     <= !evt.error && !evt.timeout;
        end
    end

    // token kind bits follow each valid token, whether or not a filter accepts it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_r[ST_SETUP] <= RST_ENGINE_STATUS[ST_SETUP];
            status_r[ST_SOF]   <= RST_ENGINE_STATUS[ST_SOF];
        end else if (token.valid) begin
            status_r[ST_SETUP] <= token.kind == SEM_PID_SETUP;
            status_r[ST_SOF]   <= token.kind == SEM_PID_SOF;
        end
    end

    // preamble flag: held until the next transaction starts, set wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_r[ST_PRE] <= RST_ENGINE_STATUS[ST_PRE];
        end else if (evt.pre_seen) begin
            status_r[ST_PRE] <= 1'b1;
        end else if (evt.start) begin
            status_r[ST_PRE] <= 1'b0;
        end
    end

    // bus reset flag: set while se0 lasts, cleared by system reset, set wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_r[ST_BUSRST] <= RST_ENGINE_STATUS[ST_BUSRST];
        end else if (evt.bus_se0) begin
            status_r[ST_BUSRST] <= 1'b1;
        end else if (evt.sys_reset) begin
            status_r[ST_BUSRST] <= 1'b0;
        end
    end

    // end flag: rises at end, falls at start, end wins on a tie
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_r[ST_TEND] <= RST_ENGINE_STATUS[ST_TEND];
        end else if (end_event) begin
            status_r[ST_TEND] <= 1'b1;
        end else if (evt.start) begin
            status_r[ST_TEND] <= 1'b0;
        end
    end

    assign transaction_end = status_r[ST_TEND];

    // read path: data stands in the cycle after the strobe only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= RDATA_IDLE;
        end else if (reg_rd && is_reg(reg_addr, OFS_ENGINE_STATUS)) begin
            rdata_r <= status_r;
        end else if (reg_rd && is_reg(reg_addr, OFS_ENGINE_CONTROL_ONE)) begin
            rdata_r <= {ctrl_r[DATA_W-1:CT_TEND], rx_tag_state, tx_success_state};
        end else begin
            rdata_r <= RDATA_IDLE;
        end
    end

    assign reg_rdata = rdata_r;

    // assertions; status writes are only watched here, they never reach status_r

    // single hit only: with overlapping filters the priority order picks another group
    a_alt_fold_map: assert property (@(posedge clk) disable iff (!resetn)
        token.valid && token.hit == (4'h1 << FILT_ALT3) && alt_filter_enable[FILT_ALT3]
        |=> internal_ep == {FILT_ALT3, $past(token.wire_ep[1:0])} && endpoint_accept)
        else $error("alternate three fold wrong");

    a_alt_one_map: assert property (@(posedge clk) disable iff (!resetn)
        token.valid && token.hit == (4'h1 << FILT_ALT1) && alt_filter_enable[FILT_ALT1]
        |=> internal_ep == {FILT_ALT1, $past(token.wire_ep[1:0])} && endpoint_accept)
        else $error("alternate one map wrong");

    a_primary_map: assert property (@(posedge clk) disable iff (!resetn)
        token.valid && token.hit[FILT_PRIMARY]
        |=> internal_ep == $past(token.wire_ep))
        else $error("primary endpoint changed");

    a_filter_disabled: assert property (@(posedge clk) disable iff (!resetn)
        token.valid && token.hit == (4'h1 << FILT_ALT2) && !alt_filter_enable[FILT_ALT2]
        |=> !endpoint_accept && !tx_queue_pop)
        else $error("disabled filter accepted");

    a_in_pop: assert property (@(posedge clk) disable iff (!resetn)
        token.valid && token.kind == SEM_PID_IN && token.hit[FILT_PRIMARY]
        |=> tx_queue_pop && ep_valid)
        else $error("in token did not pop queue");

    a_end_outcome: assert property (@(posedge clk) disable iff (!resetn)
        evt.done
        |=> status_r[ST_TEND] && status_r[ST_ERR] == $past(evt.error)
            && status_r[ST_TIMEOUT] == $past(evt.timeout)
            && status_r[ST_ACK] == !($past(evt.error) || $past(evt.timeout)))
        else $error("outcome bits wrong at end");

    a_start_clears: assert property (@(posedge clk) disable iff (!resetn)
        evt.start && !evt.done && !ctrl_r[CT_TEND] |=> !transaction_end)
        else $error("end flag not cleared at start");

    a_token_kind: assert property (@(posedge clk) disable iff (!resetn)
        token.valid |=> status_r[ST_SETUP] == ($past(token.kind) == SEM_PID_SETUP)
            && status_r[ST_SOF] == ($past(token.kind) == SEM_PID_SOF))
        else $error("token kind bits wrong");

    a_pre_set: assert property (@(posedge clk) disable iff (!resetn)
        evt.pre_seen |=> status_r[ST_PRE])
        else $error("preamble flag not set");

    a_pre_held: assert property (@(posedge clk) disable iff (!resetn)
        evt.pre_seen ##1 !evt.start[*2] |-> status_r[ST_PRE])
        else $error("preamble flag lost");

    a_busrst_clear: assert property (@(posedge clk) disable iff (!resetn)
        evt.sys_reset && !evt.bus_se0 |=> !status_r[ST_BUSRST])
        else $error("bus reset flag not cleared");

    a_busrst_set: assert property (@(posedge clk) disable iff (!resetn)
        evt.bus_se0 |=> status_r[ST_BUSRST])
        else $error("bus reset flag not set");

    a_status_read: assert property (@(posedge clk) disable iff (!resetn)
        reg_rd && reg_addr == OFS_ENGINE_STATUS |=> reg_rdata == $past(status_r))
        else $error("status read mismatch");

    a_status_ro: assert property (@(posedge clk) disable iff (!resetn)
        wr_status_ignored && !token.valid && !end_event && !evt.start
            && !evt.pre_seen && !evt.bus_se0 && !evt.sys_reset
        |=> $stable(status_r))
        else $error("status changed by write");

    a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
        !reg_rd |=> reg_rdata == RDATA_IDLE)
        else $error("read data outside read slot");

    a_unmapped_read: assert property (@(posedge clk) disable iff (!resetn)
        reg_rd && reg_addr != OFS_ENGINE_STATUS && reg_addr != OFS_ENGINE_CONTROL_ONE
        |=> reg_rdata == RDATA_IDLE)
        else $error("unmapped read not idle");

    a_ctrl_live: assert property (@(posedge clk) disable iff (!resetn)
        reg_rd && reg_addr == OFS_ENGINE_CONTROL_ONE
        |=> reg_rdata[CT_RX_TAG] == $past(rx_tag_state)
            && reg_rdata[CT_TX_OK] == $past(tx_success_state))
        else $error("live control bits wrong");

    a_ctrl_write: assert property (@(posedge clk) disable iff (!resetn)
        wr_ctrl |=> engine_dma_inhibit == $past(reg_wdata[CT_DMA_INHIBIT])
            && force_rx_accept == $past(reg_wdata[CT_RX_ACCEPT]))
        else $error("control write not applied");

    a_dma_inhibit: assert property (@(posedge clk) disable iff (!resetn)
        wr_ctrl && reg_wdata[CT_DMA_INHIBIT] ##1 dma_req |-> !dma_grant)
        else $error("dma granted while inhibited");

    a_force_ack: assert property (@(posedge clk) disable iff (!resetn)
        ctrl_r[CT_RX_ACCEPT] |-> rx_ack_send)
        else $error("forced ack missing");

    a_last_byte_once: assert property (@(posedge clk) disable iff (!resetn)
        tx_last_byte && !wr_ctrl ##1 tx_fifo_wr && !wr_ctrl |-> !tx_last_byte)
        else $error("last byte flagged twice");

    a_overflow_pulse: assert property (@(posedge clk) disable iff (!resetn)
        wr_ctrl && reg_wdata[CT_RX_OVERFLOW] && !ctrl_r[CT_RX_OVERFLOW]
        |=> rx_overflow_event && rx_fifo_flush)
        else $error("overflow not raised");

    a_overflow_once: assert property (@(posedge clk) disable iff (!resetn)
        rx_overflow_event |=> !rx_overflow_event)
        else $error("overflow event longer than one cycle");

    a_stuff_err: assert property (@(posedge clk) disable iff (!resetn)
        wr_ctrl |=> inject_stuff_error == $past(reg_wdata[CT_STUFF_ERR]))
        else $error("stuff error control wrong");

    a_forced_end: assert property (@(posedge clk) disable iff (!resetn)
        ctrl_r[CT_TEND] |=> transaction_end)
        else $error("forced end not seen");

endmodule : sem_engine_map_status

// ==== dv/sem_host_model.sv ====
// Purpose: host side model that drives tokens and engine events
// Assumes: one clock; signals change by non-blocking assignment after the edge
// Notes:   token valid holds until idle_token, event flags are one-cycle pulses, bus_se0 is a level
`timescale 1ns/1ps

module sem_host_model
    import sem_pkg::*;
(
    input  wire logic clk,
    output sem_token_t token,
    output sem_event_t evt
);
    initial begin
        token = '0;
        evt   = '0;
    end

    task automatic send_token(input sem_pid_t k, input logic [EP_W-1:0] ep,
                              input logic [NFILT-1:0] h);
        @(posedge clk);
        token <= '{1'b1, k, ep, h};
    endtask : send_token

    task automatic idle_token();
        @(posedge clk);
        token <= '0;
    endtask : idle_token

    // pulses drop after one cycle; a long se0 stays until the next call
    task automatic send_evt(input sem_event_t e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= e & 7'h02;
    endtask : send_evt
endmodule : sem_host_model

// ==== dv/sem_tb.sv ====
// Purpose: self-checking bench for endpoint map, status and control one
// Assumes: reads answer one cycle after the strobe, no wait states
// Notes:   expected values come from a bench model of both registers
`timescale 1ns/1ps

module tb;
    import sem_pkg::*;
    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    sem_token_t        token;
    sem_event_t        evt;
    logic [NFILT-1:1]  alt_filter_enable = 3'b111;
    logic              ep_valid, endpoint_accept, tx_queue_pop, dma_grant, rx_ack_send;
    logic [EP_W-1:0]   internal_ep;
    logic              rx_tag_state = 1'b0, tx_success_state = 1'b0;
    logic              dma_req = 1'b1, rx_ack_req = 1'b0, tx_fifo_wr = 1'b0;
    logic              tx_last_byte, rx_overflow_event, rx_fifo_flush, inject_stuff_error;
    logic              inject_transaction_end, engine_dma_inhibit, force_rx_accept;
    logic              transaction_end;
    logic [7:0]        rd_q[$];
    logic [15:0]       ep_q[$];
    logic [15:0]       m;
    logic [7:0]        st = 8'h03, ct = 8'h00;
    logic              rd_seen = 1'b0;
    int                err_total = 0, total_checks = 0;
    sem_pid_t          k;

    sem_engine_map_status u_sem_engine_map_status (.*);
    sem_host_model        u_sem_host_model (.clk(clk), .token(token), .evt(evt));

    always #5 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        rd_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic tok(input sem_pid_t kk, input logic [3:0] ep, input logic [3:0] h,
                       input logic [7:0] msk, input logic [7:0] x);
        u_sem_host_model.send_token(kk, ep, h);
        ep_q.push_back({msk, x});
        st[5] = (kk == SEM_PID_SETUP);
        st[4] = (kk == SEM_PID_SOF);
    endtask : tok

    // send one event, update the status model, read status back
    task automatic ev(input logic [6:0] e, input logic [7:0] clr, input logic [7:0] set);
        u_sem_host_model.send_evt(sem_event_t'(e));
        st = (st & ~clr) | set;
        rd(OFS_ENGINE_STATUS, st);
    endtask : ev

    function automatic logic [7:0] ovr();
        return {engine_dma_inhibit, dma_grant, force_rx_accept, rx_ack_send,
                rx_overflow_event, rx_fifo_flush, inject_stuff_error, inject_transaction_end};
    endfunction : ovr

    // results are taken off the queues when the design presents them
    always @(negedge clk) begin
        if (rd_seen) check(reg_rdata, rd_q.pop_front());
        rd_seen = reg_rd;
        if (ep_valid === 1'b1) begin
            m = ep_q.pop_front();
            check({2'b00, endpoint_accept, tx_queue_pop, internal_ep} & m[15:8],
                  m[7:0] & m[15:8]);
        end
    end

    initial begin
        #100000;
        err_total++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h3199));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1 check({7'h0, transaction_end}, 8'h01);
        check(ovr(), 8'h40);
        rd(OFS_ENGINE_STATUS, 8'h03);
        wr(OFS_ENGINE_STATUS, 8'hff);
        rd(OFS_ENGINE_STATUS, 8'h03);
        for (int i = 0; i < 4; i++) begin
            rx_tag_state     <= i[1];
            tx_success_state <= i[0];
            rd(OFS_ENGINE_CONTROL_ONE, {ct[7:2], i[1:0]});
        end
        wr(16'h7f95, 8'hff);
        rd(16'h7f95, 8'h00);
        rd(OFS_ENGINE_CONTROL_ONE, {ct[7:2], 2'b11});
        // back-to-back tokens through every filter and every wire endpoint
        for (int f = 0; f < 4; f++) begin
            for (int e = 0; e < 16; e++) begin
                k = sem_pid_t'($urandom_range(3, 0));
                tok(k, 4'(e), 4'h1 << f, 8'hff, {2'b00, 1'b1, k == SEM_PID_IN,
                    (f == 0) ? 4'(e) : {2'(f), 2'(e)}});
            end
        end
        // let the last enabled token be sampled before the filters drop
        u_sem_host_model.idle_token();
        alt_filter_enable <= 3'b000;
        for (int f = 1; f < 4; f++) begin
            tok(sem_pid_t'($urandom_range(3, 0)), 4'($urandom_range(15, 0)),
                4'h1 << f, 8'h30, 8'h00);
        end
        u_sem_host_model.idle_token();
        alt_filter_enable <= 3'b111;
        for (int i = 0; i < 4; i++) begin
            tok(sem_pid_t'(i), 4'h0, 4'h1, 8'hff, {3'b001, i == 1, 4'h0});
            u_sem_host_model.idle_token();
            rd(OFS_ENGINE_STATUS, st);
        end
        ev(7'h40, 8'h09, 8'h00);
        ev(7'h04, 8'h00, 8'h08);
        ev(7'h30, 8'hc5, 8'h81);
        ev(7'h40, 8'h09, 8'h00);
        ev(7'h28, 8'hc5, 8'h41);
        ev(7'h40, 8'h09, 8'h00);
        ev(7'h20, 8'hc5, 8'h05);
        ev(7'h01, 8'h02, 8'h00);
        ev(7'h02, 8'h00, 8'h02);
        ev(7'h00, 8'h00, 8'h00);
        ev(7'h01, 8'h02, 8'h00);
        ev(7'h40, 8'h09, 8'h00);
        // every override at once; low two bits of the write must not stick
        wr(OFS_ENGINE_CONTROL_ONE, 8'hff);
        ct = 8'hfc;
        #1 check(ovr(), 8'hbf);
        @(posedge clk);
        #1 check({7'h0, rx_overflow_event}, 8'h00);
        st = (st & 8'h3a) | 8'h05;
        rd(OFS_ENGINE_STATUS, st);
        @(posedge clk);
        tx_fifo_wr <= 1'b1;
        #1 check({7'h0, tx_last_byte}, 8'h01);
        @(posedge clk);
        #1 check({7'h0, tx_last_byte}, 8'h00);
        @(posedge clk);
        tx_fifo_wr <= 1'b0;
        ct[5] = 1'b0;
        rd(OFS_ENGINE_CONTROL_ONE, {ct[7:2], 2'b11});
        wr(OFS_ENGINE_CONTROL_ONE, 8'h00);
        ct = 8'h00;
        #1 check(ovr(), 8'h40);
        @(posedge clk);
        rx_ack_req <= 1'b1;
        dma_req    <= 1'b0;
        #1 check(ovr(), 8'h10);
        rd(OFS_ENGINE_CONTROL_ONE, {ct[7:2], 2'b11});
        rd(OFS_ENGINE_STATUS, st);
        // mid-run reset must bring status back to its reset value
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        st = 8'h03;
        rd(OFS_ENGINE_STATUS, st);
        repeat (3) @(posedge clk);
        check(8'(rd_q.size() + ep_q.size()), 8'h00);
        print_verdict();
    end
endmodule : tb
